// file: common/freq_ref_pkg.sv
// Constants, register map and enums for the analog frequency reference scaler
// Assumes a 32-bit classic Wishbone register bus on one clock
`default_nettype none
package freq_ref_pkg;
  // ************************************************************
  // Widths and ranges
  // ************************************************************
  localparam int          SAMPLE_W      = 12;
  localparam int          FREQ_W        = 12;
  localparam int          PCT_W         = 7;
  localparam int          FILTER_DEPTH  = 16;
  localparam int          IDX_W         = 4;
  localparam int          SUM_W         = 16;
  localparam logic [11:0] SAMPLE_FULL   = 12'hFFF;
  // Frequencies are in 0.1 Hz steps: 400.0 Hz is 4000
  localparam logic [11:0] FREQ_MAX      = 12'hFA0;
  localparam logic [6:0]  PCT_MAX       = 7'h64;
  // Deadband in 0.1 Hz steps
  localparam logic [11:0] DEADBAND_UP   = 12'h001;
  localparam logic [11:0] DEADBAND_DOWN = 12'h002;
  localparam logic [4:0]  FILTER_DEAD   = 5'h11;
  localparam logic [4:0]  FILTER_MAX_N  = 5'h10;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_SOURCE    = 8'h00;
  localparam logic [7:0] OFS_VOLT_FREQ = 8'h04;
  localparam logic [7:0] OFS_VOLT_PCT  = 8'h08;
  localparam logic [7:0] OFS_CURR_FREQ = 8'h0C;
  localparam logic [7:0] OFS_CURR_PCT  = 8'h10;
  localparam logic [7:0] OFS_FILTER    = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int FLD_HI_LSB     = 16;
  localparam int FLD_CHOICE_BIT = 8;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [1:0]  RST_SOURCE    = 2'h0;
  localparam logic [11:0] RST_FREQ      = 12'h000;
  localparam logic [6:0]  RST_START_PCT = 7'h00;
  localparam logic [6:0]  RST_END_PCT   = 7'h64;
  localparam logic        RST_CHOICE    = 1'b1;
  localparam logic [4:0]  RST_FILTER    = 5'h08;

  typedef enum logic [1:0] {
    SRC_VOLT_CURR = 2'b00,
    SRC_SUM       = 2'b01,
    SRC_VOLT_POT  = 2'b10,
    SRC_CURR_POT  = 2'b11
  } source_e;
endpackage : freq_ref_pkg
`default_nettype wire

// file: design/line_segment_map.sv
// Maps one digitized input onto a clipped frequency line segment
// Assumes settings are stable across a sample and start below end
`timescale 1ns/10ps
`default_nettype none
module line_segment_map (
  input  wire logic [freq_ref_pkg::SAMPLE_W-1:0] sample_in,
  input  wire logic [freq_ref_pkg::FREQ_W-1:0]   start_freq_in,
  input  wire logic [freq_ref_pkg::FREQ_W-1:0]   end_freq_in,
  input  wire logic [freq_ref_pkg::PCT_W-1:0]    start_pct_in,
  input  wire logic [freq_ref_pkg::PCT_W-1:0]    end_pct_in,
  input  wire logic                              below_choice_in,
  output logic      [freq_ref_pkg::FREQ_W-1:0]   freq_out
);
  import freq_ref_pkg::*;

  // ************************************************************
  // Input percent in 1/4095 units scaled by 100
  // ************************************************************
  wire logic [18:0] scaled_in  = 19'(sample_in) * 19'd100;
  wire logic [18:0] start_pos  = 19'(start_pct_in) * 19'(SAMPLE_FULL);
  wire logic [18:0] end_pos    = 19'(end_pct_in) * 19'(SAMPLE_FULL);
  wire logic        below      = scaled_in < start_pos;
  wire logic        above      = scaled_in > end_pos;
  wire logic        at_origin  = (start_freq_in == RST_FREQ) &&
                                 (start_pct_in == RST_START_PCT);
  wire logic [18:0] span_in    = (end_pos > start_pos) ?
                                 end_pos - start_pos : 19'd1;
  wire logic [18:0] offset_in  = scaled_in - start_pos;
  wire logic        rising     = end_freq_in >= start_freq_in;
  wire logic [11:0] span_freq  = rising ? end_freq_in - start_freq_in
                                        : start_freq_in - end_freq_in;
  wire logic [30:0] product    = 31'(offset_in) * 31'(span_freq);
  wire logic [30:0] quotient   = product / 31'(span_in);
  wire logic [12:0] delta      = (quotient > 31'(span_freq)) ?
                                 13'(span_freq) : quotient[12:0];
  wire logic [12:0] line_val   = rising ? 13'(start_freq_in) + delta
                                        : 13'(start_freq_in) - delta;
  wire logic [11:0] low_val    = (below_choice_in && !at_origin) ?
                                 RST_FREQ : start_freq_in;
  wire logic [11:0] mapped     = below ? low_val
                               : above ? end_freq_in
                               : line_val[11:0];
  // Keep the result inside the legal frequency range
  assign freq_out = (mapped > FREQ_MAX) ? FREQ_MAX : mapped;
endmodule : line_segment_map
`default_nettype wire

// file: design/analog_freq_reference_scaler.sv
// Analog input to frequency reference: mapping, source select, filtering
// Assumes one sample strobe per converter result and a Wishbone master
// How it works
// - Voltage input mapped linearly between percent endpoints
// - Voltage endpoint frequencies limited to 0..400 Hz
// - Below voltage start: start frequency or 0 Hz
// - Above voltage end: clamp to end frequency
// - Current input uses its own separate line
// - Below current start: start frequency or 0 Hz
// - Above current end: clamp to end frequency
// - Selector picks pair, sum, or potentiometer
// - Settings 1..16 give n-sample moving average
// - Setting 17 applies 16-sample averages with deadband
// - Small change inside deadband leaves output unchanged
// - Change beyond deadband applies and moves point
`timescale 1ns/10ps
`default_nettype none
module analog_freq_reference_scaler (
  input  wire logic                              mclk_in,
  input  wire logic                              srst_in,
  input  wire logic                              sample_valid_in,
  input  wire logic [freq_ref_pkg::SAMPLE_W-1:0] volt_sample_in,
  input  wire logic [freq_ref_pkg::SAMPLE_W-1:0] current_input_terminal_in,
  input  wire logic [freq_ref_pkg::FREQ_W-1:0]   pot_freq_in,
  input  wire logic                              analog_select_input_in,
  input  wire logic                              wb_cyc_in,
  input  wire logic                              wb_stb_in,
  input  wire logic                              wb_we_in,
  input  wire logic [7:0]                        wb_adr_in,
  input  wire logic [3:0]                        wb_sel_in,
  input  wire logic [31:0]                       wb_dat_in,
  output logic      [31:0]                       wb_dat_out,
  output logic                                   wb_ack_out,
  output logic      [freq_ref_pkg::FREQ_W-1:0]   freq_ref_out,
  output logic                                   freq_ref_valid_out
);
  import freq_ref_pkg::*;

  // ************************************************************
  // Settings
  // ************************************************************
  logic [1:0]  analog_source_select;
  logic [11:0] volt_start_frequency;
  logic [11:0] volt_end_frequency;
  logic [6:0]  volt_start_percent;
  logic [6:0]  volt_end_percent;
  logic        volt_below_start_choice;
  logic [11:0] current_start_frequency;
  logic [11:0] current_end_frequency;
  logic [6:0]  current_start_percent;
  logic [6:0]  current_end_percent;
  logic        current_below_start_choice;
  logic [4:0]  input_filter_setting;
  logic [11:0] deadband_point;

  // ************************************************************
  // Pin synchronisers (three stages, second and third must agree)
  // ************************************************************
  logic [2:0] sel_sync;
  logic       sel_level;
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sel_sync  <= 3'h0;
      sel_level <= 1'b0;
    end else begin
      sel_sync <= {sel_sync[1:0], analog_select_input_in};
      if (sel_sync[1] == sel_sync[2]) begin
        sel_level <= sel_sync[2];
      end
    end
  end

  // ************************************************************
  // Wishbone slave
  // ************************************************************
  wire logic        wb_req     = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire logic        wb_wr      = wb_req && wb_we_in && (wb_sel_in == 4'hF);
  wire logic [11:0] wr_lo      = (wb_dat_in[11:0] > FREQ_MAX) ?
                                 FREQ_MAX : wb_dat_in[11:0];
  wire logic [11:0] wr_hi      = (wb_dat_in[27:16] > FREQ_MAX) ?
                                 FREQ_MAX : wb_dat_in[27:16];
  wire logic [6:0]  wr_pct_lo  = (wb_dat_in[6:0] > PCT_MAX) ?
                                 PCT_MAX : wb_dat_in[6:0];
  wire logic [6:0]  wr_pct_hi  = (wb_dat_in[22:16] > PCT_MAX) ?
                                 PCT_MAX : wb_dat_in[22:16];
  wire logic [4:0]  wr_filter  = (wb_dat_in[4:0] == 5'h00) ? 5'h01 :
                                 (wb_dat_in[4:0] > FILTER_DEAD) ?
                                 FILTER_DEAD : wb_dat_in[4:0];

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      analog_source_select       <= RST_SOURCE;
      volt_start_frequency       <= RST_FREQ;
      volt_end_frequency         <= RST_FREQ;
      volt_start_percent         <= RST_START_PCT;
      volt_end_percent           <= RST_END_PCT;
      volt_below_start_choice    <= RST_CHOICE;
      current_start_frequency    <= RST_FREQ;
      current_end_frequency      <= RST_FREQ;
      current_start_percent      <= RST_START_PCT;
      current_end_percent        <= RST_END_PCT;
      current_below_start_choice <= RST_CHOICE;
      input_filter_setting       <= RST_FILTER;
    end else if (wb_wr) begin
      case (wb_adr_in)
        OFS_SOURCE: analog_source_select <= wb_dat_in[1:0];
        OFS_VOLT_FREQ: begin
          volt_start_frequency <= wr_lo;
          volt_end_frequency   <= wr_hi;
        end
        OFS_VOLT_PCT: begin
          volt_start_percent      <= wr_pct_lo;
          volt_end_percent        <= wr_pct_hi;
          volt_below_start_choice <= wb_dat_in[FLD_CHOICE_BIT];
        end
        OFS_CURR_FREQ: begin
          current_start_frequency <= wr_lo;
          current_end_frequency   <= wr_hi;
        end
        OFS_CURR_PCT: begin
          current_start_percent      <= wr_pct_lo;
          current_end_percent        <= wr_pct_hi;
          current_below_start_choice <= wb_dat_in[FLD_CHOICE_BIT];
        end
        OFS_FILTER: input_filter_setting <= wr_filter;
        default: ;
      endcase
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_in)
      OFS_SOURCE:    rd_mux = {30'h0, analog_source_select};
      OFS_VOLT_FREQ: rd_mux = {4'h0, volt_end_frequency,
                               4'h0, volt_start_frequency};
      OFS_VOLT_PCT:  rd_mux = {9'h0, volt_end_percent, 7'h0,
                               volt_below_start_choice, 1'b0,
                               volt_start_percent};
      OFS_CURR_FREQ: rd_mux = {4'h0, current_end_frequency,
                               4'h0, current_start_frequency};
      OFS_CURR_PCT:  rd_mux = {9'h0, current_end_percent, 7'h0,
                               current_below_start_choice, 1'b0,
                               current_start_percent};
      OFS_FILTER:    rd_mux = {27'h0, input_filter_setting};
      OFS_STATUS:    rd_mux = {4'h0, deadband_point, 3'h0,
                               sel_level, freq_ref_out};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= wb_req;
      wb_dat_out <= wb_req ? rd_mux : 32'h0000_0000;
    end
  end

  // ************************************************************
  // Line segments
  // ************************************************************
  wire logic [11:0] volt_freq;
  wire logic [11:0] curr_freq;

  line_segment_map volt_map (
    .sample_in       (volt_sample_in),
    .start_freq_in   (volt_start_frequency),
    .end_freq_in     (volt_end_frequency),
    .start_pct_in    (volt_start_percent),
    .end_pct_in      (volt_end_percent),
    .below_choice_in (volt_below_start_choice),
    .freq_out        (volt_freq)
  );

  line_segment_map curr_map (
    .sample_in       (current_input_terminal_in),
    .start_freq_in   (current_start_frequency),
    .end_freq_in     (current_end_frequency),
    .start_pct_in    (current_start_percent),
    .end_pct_in      (current_end_percent),
    .below_choice_in (current_below_start_choice),
    .freq_out        (curr_freq)
  );

  // ************************************************************
  // Source selection
  // ************************************************************
  wire logic [12:0] sum_raw  = 13'(volt_freq) + 13'(curr_freq);
  wire logic [11:0] sum_sat  = (sum_raw > 13'(FREQ_MAX)) ?
                               FREQ_MAX : sum_raw[11:0];
  wire logic [11:0] pot_sat  = (pot_freq_in > FREQ_MAX) ?
                               FREQ_MAX : pot_freq_in;
  logic [11:0] selected;
  always_comb begin
    selected = volt_freq;
    case (source_e'(analog_source_select))
      SRC_VOLT_CURR: selected = sel_level ? curr_freq : volt_freq;
      SRC_SUM:       selected = sum_sat;
      SRC_VOLT_POT:  selected = sel_level ? pot_sat : volt_freq;
      SRC_CURR_POT:  selected = sel_level ? pot_sat : curr_freq;
      default:       selected = volt_freq;
    endcase
  end

  // ************************************************************
  // Sample history and moving average
  // ************************************************************
  logic [11:0] history [FILTER_DEPTH];
  logic [3:0]  count16;
  logic        primed;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      history[0] <= 12'h000;
    end else if (sample_valid_in) begin
      history[0] <= selected;
    end
  end

  genvar g;
  generate
    for (g = 1; g < FILTER_DEPTH; g++) begin : g_hist
      always_ff @(posedge mclk_in) begin
        if (srst_in) begin
          history[g] <= 12'h000;
        end else if (sample_valid_in) begin
          history[g] <= history[g-1];
        end
      end
    end
  endgenerate

  // Average over the newest n samples including the incoming one
  wire logic [4:0] n_avg = (input_filter_setting >= FILTER_MAX_N) ?
                           FILTER_MAX_N : input_filter_setting;
  logic [SUM_W-1:0] window_sum;
  always_comb begin
    window_sum = 16'(selected);
    for (int i = 0; i < FILTER_DEPTH - 1; i++) begin
      if (5'(i + 1) < n_avg) begin
        window_sum = window_sum + 16'(history[i]);
      end
    end
  end
  wire logic [11:0] avg = 12'(window_sum / 16'(n_avg));

  wire logic        dead_mode = input_filter_setting == FILTER_DEAD;
  wire logic        up_move   = (avg >= deadband_point) &&
                                (avg - deadband_point > DEADBAND_UP);
  wire logic        dn_move   = (avg < deadband_point) &&
                                (deadband_point - avg > DEADBAND_DOWN);
  wire logic        block_end = count16 == 4'hF;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      freq_ref_out       <= 12'h000;
      freq_ref_valid_out <= 1'b0;
      count16            <= 4'h0;
      primed             <= 1'b0;
      deadband_point     <= 12'h000;
    end else begin
      freq_ref_valid_out <= 1'b0;
      if (sample_valid_in) begin
        count16 <= count16 + 4'h1;
        if (!dead_mode) begin
          freq_ref_out       <= avg;
          freq_ref_valid_out <= 1'b1;
          primed             <= 1'b0;
        end else if (block_end) begin
          if (!primed) begin
            freq_ref_out       <= avg;
            deadband_point     <= avg;
            freq_ref_valid_out <= 1'b1;
            primed             <= 1'b1;
          end else if (up_move || dn_move) begin
            freq_ref_out       <= avg;
            deadband_point     <= avg;
            freq_ref_valid_out <= 1'b1;
          end
        end
      end
    end
  end
endmodule : analog_freq_reference_scaler
`default_nettype wire

// file: test/adc_sample_model.sv
// Converter model: delivers voltage and current codes with a strobe
// Assumes the block takes one sample on each strobed rising edge
`timescale 1ns/10ps
`default_nettype none
module adc_sample_model (
  input  wire logic                              clk_in,
  output logic                                   valid_out,
  output logic      [freq_ref_pkg::SAMPLE_W-1:0] volt_out,
  output logic      [freq_ref_pkg::SAMPLE_W-1:0] current_out
);
  import freq_ref_pkg::*;
  initial begin
    valid_out = 1'b0;
    volt_out = 12'h000;
    current_out = 12'hFFF;
  end
  // Back-to-back strobes, then inverted codes while idle
  task automatic burst(input logic [11:0] v, c, input int n, gap);
    repeat (n) begin
      @(posedge clk_in);
      valid_out <= 1'b1;
      volt_out <= v;
      current_out <= c;
    end
    @(posedge clk_in);
    valid_out <= 1'b0;
    volt_out <= ~v;
    current_out <= ~c;
    repeat (gap) @(posedge clk_in);
  endtask : burst
endmodule : adc_sample_model
`default_nettype wire

// file: test/freq_ref_asserts.sv
// Checker for bus answers and reference updates of the scaler
// Assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module freq_ref_checker (
  input wire logic        mclk_in,
  input wire logic        srst_in,
  input wire logic        sample_valid_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic [11:0] freq_ref_out,
  input wire logic        freq_ref_valid_out
);
  import freq_ref_pkg::*;
  logic [4:0] filt;
  logic       seen;
  wire  logic [4:0] wr_val = wb_dat_in[4:0];
  wire  logic       filt_wr = wb_cyc_in & wb_stb_in & wb_we_in & ~wb_ack_out
                              & (wb_sel_in == 4'hF)
                              & (wb_adr_in == OFS_FILTER);
  wire  logic [4:0] next_filt = (wr_val == 5'h00) ? 5'h01 :
                                (wr_val > FILTER_DEAD) ? FILTER_DEAD : wr_val;
  // Tracks filter mode and whether a first block was applied
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      filt <= RST_FILTER;
      seen <= 1'b0;
    end else if (filt_wr) begin
      filt <= next_filt;
      seen <= 1'b0;
    end else if (freq_ref_valid_out && filt == FILTER_DEAD) begin
      seen <= 1'b1;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  AST_ACK_NEXT: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
    |=> wb_ack_out) else $error("bus request not answered next cycle");
  AST_ACK_ONE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("bus answer longer than one cycle");
  AST_IDLE_DATA: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data not zero outside answer");
  AST_UNMAPPED: assert property (wb_ack_out && $past(wb_adr_in) >= 8'h1C
    |-> wb_dat_out == 32'h0) else $error("unmapped read not zero");
  AST_RANGE: assert property (freq_ref_out <= FREQ_MAX)
    else $error("reference above top frequency");
  AST_HOLD: assert property (!freq_ref_valid_out |-> $stable(freq_ref_out))
    else $error("reference moved without update strobe");
  AST_NO_SAMPLE: assert property (!sample_valid_in |=> !freq_ref_valid_out)
    else $error("update strobe without sample");
  AST_EVERY: assert property (sample_valid_in && filt != FILTER_DEAD
    |=> freq_ref_valid_out) else $error("sample gave no update");
  AST_DEADBAND: assert property (freq_ref_valid_out && filt == FILTER_DEAD
    && seen |-> freq_ref_out > $past(freq_ref_out) + 12'h001
    || freq_ref_out + 12'h002 < $past(freq_ref_out))
    else $error("update applied inside deadband");
endmodule : freq_ref_checker
bind analog_freq_reference_scaler freq_ref_checker freq_ref_checker_inst (
  .mclk_in(mclk_in), .srst_in(srst_in), .sample_valid_in(sample_valid_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
  .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .freq_ref_out(freq_ref_out), .freq_ref_valid_out(freq_ref_valid_out));
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the analog frequency reference scaler
// Assumes the converter model strobes samples and the bench is bus master
`timescale 1ns/10ps
`default_nettype none
module tb;
  import freq_ref_pkg::*;
  logic        mclk = 0, srst = 1, cyc = 0, stb = 0, we = 0, asel = 0;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] dat = 0;
  logic [11:0] pot = 0;
  wire  logic [31:0] rdat;
  wire  logic        ack, sv, fqv;
  wire  logic [11:0] vs, cs, fq;
  logic [31:0] rd_q[$];
  logic [11:0] fq_q[$];
  int          errors = 0, cmp_count = 0, cycles = 0, seed = 30485;
  analog_freq_reference_scaler analog_freq_reference_scaler_inst (
    .mclk_in(mclk), .srst_in(srst), .sample_valid_in(sv),
    .volt_sample_in(vs), .current_input_terminal_in(cs), .pot_freq_in(pot),
    .analog_select_input_in(asel), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .freq_ref_out(fq),
    .freq_ref_valid_out(fqv));
  adc_sample_model adc_inst (.clk_in(mclk), .valid_out(sv), .volt_out(vs),
    .current_out(cs));
  initial forever #10 mclk = ~mclk;
  task automatic summarize();
    if (rd_q.size() != 0 || fq_q.size() != 0) errors++;
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic chk_rd(input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR read data expected %h seen %h", e, g);
    end
  endtask : chk_rd
  task automatic chk_fq(input logic [11:0] e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR freq_ref expected %h seen %h", e, g);
    end
  endtask : chk_fq
  // Result watcher: oldest noted expectation per kind of result
  always @(posedge mclk) begin
    if (ack === 1'b1 && we === 1'b0) chk_rd(rd_q.size() ? rd_q.pop_front() : 'x, rdat);
    if (fqv === 1'b1) chk_fq(fq_q.size() ? fq_q.pop_front() : 'x, fq);
    cycles++;
    if (cycles == 6000) begin
      errors++;
      $display("ERROR timeout expected %0d seen %0d", 5999, cycles);
      summarize();
    end
  end
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge mclk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(a, 1'b0, 32'h0, 4'hF);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, 1'b1, d, 4'hF);
  endtask : wr
  task automatic smp(input logic [11:0] v, c, e, input int n, p);
    if (p != 0) fq_q.push_back(e);
    adc_inst.burst(v, c, n, 2);
  endtask : smp
  task automatic rst();
    @(posedge mclk);
    srst <= 1'b1;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
  endtask : rst
  initial begin
    int          r, c, s, a;
    logic [11:0] e;
    rst();
    rd(OFS_SOURCE, 32'h0);
    rd(OFS_VOLT_FREQ, 32'h0);
    rd(OFS_VOLT_PCT, 32'h00640100);
    rd(OFS_CURR_PCT, 32'h00640100);
    rd(OFS_FILTER, 32'h8);
    rd(OFS_STATUS, 32'h0);
    rd(8'h1C, 32'h0);
    wr(OFS_VOLT_FREQ, 32'h0FFF0FA1);
    rd(OFS_VOLT_FREQ, 32'h0FA00FA0);
    wr(OFS_VOLT_PCT, 32'h007F0065);
    rd(OFS_VOLT_PCT, 32'h00640064);
    wb(OFS_FILTER, 1'b1, 32'h3, 4'h1);
    rd(OFS_FILTER, 32'h8);
    wr(OFS_FILTER, 32'h0);
    rd(OFS_FILTER, 32'h1);
    wr(OFS_FILTER, 32'h1F);
    rd(OFS_FILTER, 32'h11);
    rst();
    wr(OFS_VOLT_FREQ, 32'h0FA00000);
    wr(OFS_FILTER, 32'h11);
    smp(12'hFFF, 0, 12'hFA0, 16, 1);
    smp(12'hFFF, 0, 0, 16, 0);
    smp(12'hFFE, 0, 0, 16, 0);
    smp(12'hFFC, 0, 12'hF9D, 16, 1);
    smp(12'hFFD, 0, 0, 16, 0);
    smp(12'hFFE, 0, 12'hF9F, 16, 1);
    rd(OFS_STATUS, 32'h0F9F0F9F);
    wr(OFS_FILTER, 32'h4);
    for (r = 3; r >= 0; r--) smp(0, 0, 12'(3999 * r / 4), 1, 1);
    wr(OFS_FILTER, 32'h1);
    smp(12'hFFF, 0, 12'hFA0, 1, 1);
    repeat (12) begin
      r = $random(seed) & 32'hFFF;
      c = $random(seed) & 32'hFFF;
      smp(12'(r), 12'(c), 12'(r * 4000 / 4095), 1, 1);
    end
    wr(OFS_VOLT_FREQ, 32'h0BB803E8);
    wr(OFS_VOLT_PCT, 32'h00500114);
    smp(0, 0, 0, 1, 1);
    wr(OFS_VOLT_PCT, 32'h00500014);
    smp(0, 0, 12'h3E8, 1, 1);
    smp(12'hFFF, 0, 12'hBB8, 1, 1);
    wr(OFS_CURR_FREQ, 32'h025800C8);
    wr(OFS_CURR_PCT, 32'h005A000A);
    asel <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(OFS_STATUS, 32'h0F9F1BB8);
    smp(12'hFFF, 0, 12'h0C8, 1, 1);
    smp(0, 12'hFFF, 12'h258, 1, 1);
    wr(OFS_CURR_PCT, 32'h005A010A);
    smp(0, 0, 0, 1, 1);
    pot <= 12'h07B;
    for (s = 0; s < 4; s++) for (a = 0; a < 2; a++) begin
      wr(OFS_SOURCE, 32'(s));
      asel <= a[0];
      repeat (8) @(posedge mclk);
      e = s == 1 ? 12'hE10 : a ? (s == 0 ? 12'h258 : 12'h07B)
                               : (s == 3 ? 12'h258 : 12'hBB8);
      smp(12'hFFF, 12'hFFF, e, 1, 1);
    end
    wr(OFS_VOLT_FREQ, 32'h0FA003E8);
    wr(OFS_SOURCE, 32'h1);
    smp(12'hFFF, 12'hFFF, 12'hFA0, 1, 1);
    repeat (4) @(posedge mclk);
    summarize();
  end
endmodule : tb
`default_nettype wire
